/* strap_latch.sv */
// Purpose: Shared constants and types, and the four-level strap decoder and latch
// Assumes: Each strap arrives as three threshold comparator outputs (thermometer)
// Notes:   Codes are captured once, on the capture pulse after internal reset
package redriver_pkg;
  localparam int unsigned CLK_MHZ              = 50;
  localparam int unsigned POWER_GOOD_DELAY_US  = 500;
  localparam int unsigned POWER_GOOD_CYCLES    = POWER_GOOD_DELAY_US * CLK_MHZ;
  localparam int unsigned STRAP_HOLD_TIME_US   = 10;
  localparam int unsigned STRAP_HOLD_CYCLES    = STRAP_HOLD_TIME_US * CLK_MHZ;
  localparam int unsigned STRAP_SETUP_TIME_US  = 50;
  localparam int unsigned RX_DETECT_INTERVAL_MS = 12;
  localparam int unsigned RX_DETECT_CYCLES     = RX_DETECT_INTERVAL_MS * 1000 * CLK_MHZ;

  localparam int unsigned NUM_STRAPS    = 6;
  localparam int unsigned STRAP_MODE    = 0;
  localparam int unsigned STRAP_EQ0     = 1;
  localparam int unsigned STRAP_EQ1     = 2;
  localparam int unsigned STRAP_SSEQ0   = 3;
  localparam int unsigned STRAP_SSEQ1   = 4;
  localparam int unsigned STRAP_ADDR_HI = 5;

  localparam logic [2:0] THERMO_R = 3'h1;
  localparam logic [2:0] THERMO_F = 3'h3;
  localparam logic [2:0] THERMO_1 = 3'h7;
  localparam logic [1:0] LEVEL_0  = 2'h0;
  localparam logic [1:0] LEVEL_R  = 2'h1;
  localparam logic [1:0] LEVEL_F  = 2'h2;
  localparam logic [1:0] LEVEL_1  = 2'h3;

  localparam logic [4:0] ADDR_UPPER_0 = 5'h11;
  localparam logic [4:0] ADDR_UPPER_R = 5'h08;
  localparam logic [4:0] ADDR_UPPER_F = 5'h04;
  localparam logic [4:0] ADDR_UPPER_1 = 5'h03;

  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_RX_EQ       = 8'h01;
  localparam logic [7:0] REG_HOST_EQ     = 8'h02;
  localparam logic [7:0] REG_STATUS      = 8'h03;
  localparam int unsigned CTRL_PATH_EN_BIT = 0;
  localparam int unsigned CTRL_ORIENT_BIT  = 1;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] RX_EQ_RESET     = 8'h00;
  localparam logic [7:0] HOST_EQ_RESET   = 8'h00;

  typedef logic [2:0] strap_thermo_type;
  typedef logic [1:0] strap_code_type;

  typedef struct packed {
    logic [3:0] rx1;
    logic [3:0] rx2;
    logic [3:0] host;
  } eq_set_type;

  typedef struct packed {
    logic term_conn;
    logic term_host;
    logic eidle_conn;
    logic eidle_host;
    logic lfps_conn;
    logic lfps_host;
    logic u2_entry_lfps;
  } link_in_type;

  typedef enum logic [3:0] {
    LS_DISCONNECT = 4'b0001,
    LS_U0         = 4'b0010,
    LS_U1         = 4'b0100,
    LS_U2U3       = 4'b1000
  } link_state_type;

  typedef enum logic [9:0] {
    I2C_IDLE     = 10'b0000000001,
    I2C_ADDR     = 10'b0000000010,
    I2C_ADDR_ACK = 10'b0000000100,
    I2C_OFFS     = 10'b0000001000,
    I2C_OFFS_ACK = 10'b0000010000,
    I2C_WDATA    = 10'b0000100000,
    I2C_WACK     = 10'b0001000000,
    I2C_RDATA    = 10'b0010000000,
    I2C_RACK     = 10'b0100000000,
    I2C_WAIT_P   = 10'b1000000000
  } i2c_state_type;
endpackage : redriver_pkg

`timescale 1ns/1ps
module strap_latch (
  input  wire logic                                                 clk,
  input  wire logic                                                 rst_n,
  input  wire logic                                                 capture,
  input  wire redriver_pkg::strap_thermo_type [redriver_pkg::NUM_STRAPS-1:0] level,
  output      redriver_pkg::strap_code_type   [redriver_pkg::NUM_STRAPS-1:0] code
);
  import redriver_pkg::*;

  strap_code_type [NUM_STRAPS-1:0] code_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STRAPS; gi++) begin : g_strap
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          code_q[gi] <= LEVEL_0;
        end else if (capture) begin
          case (level[gi])
            THERMO_R: code_q[gi] <= LEVEL_R;
            THERMO_F: code_q[gi] <= LEVEL_F;
            THERMO_1: code_q[gi] <= LEVEL_1;
            default:  code_q[gi] <= LEVEL_0;
          endcase
        end
      end
    end
  endgenerate

  assign code = code_q;
endmodule : strap_latch

/* redriver_control.sv */
// Purpose: Control logic of a linear USB redriver with 2:1 mux
// Assumes: All inputs synchronous to clk; rst_n release marks supply at minimum
// Notes:   Register target answers only in I2C mode; sda drives low only
`timescale 1ns/1ps
module redriver_control #(
  parameter int unsigned PG_CYCLES    = redriver_pkg::POWER_GOOD_CYCLES,
  parameter int unsigned RXDET_CYCLES = redriver_pkg::RX_DETECT_CYCLES
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire redriver_pkg::strap_thermo_type      mode_strap,
  input  wire redriver_pkg::strap_thermo_type [1:0] conn_rx_eq_straps,
  input  wire redriver_pkg::strap_thermo_type [1:0] host_tx_eq_straps,
  input  wire redriver_pkg::strap_thermo_type      addr_hi_strap,
  input  wire logic                                path_enable_pin,
  input  wire logic                                orientation_pin,
  input  wire redriver_pkg::link_in_type           link_in,
  input  wire logic                                scl,
  input  wire logic                                sda_in,
  output      logic                                sda_out,
  output      logic                                sda_oe,
  output      logic                                power_good,
  output      logic                                strap_bias_en,
  output      logic                                i2c_mode,
  output      logic [6:0]                          target_addr,
  output      logic                                path_active,
  output      logic                                orient_lane2,
  output      redriver_pkg::eq_set_type            eq_set,
  output      logic [2:0]                          eq_enable,
  output      redriver_pkg::link_state_type        link_state,
  output      logic                                rx_term_en,
  output      logic                                tx_cm_en,
  output      logic                                redrive_en,
  output      logic                                rx_detect_req
);
  import redriver_pkg::*;

  localparam logic [15:0] PG_LAST   = 16'(PG_CYCLES - 1);
  localparam logic [9:0]  HOLD_LAST = 10'(STRAP_HOLD_CYCLES - 1);
  localparam logic [19:0] DET_LAST  = 20'(RXDET_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Internal power-good and strap capture
  logic [15:0]     pg_cnt_q;
  logic            pg_q;
  logic            capture_q;
  logic [9:0]      hold_cnt_q;
  logic            bias_q;
  logic            latched_q;
  strap_thermo_type [NUM_STRAPS-1:0] strap_lvl;
  strap_code_type   [NUM_STRAPS-1:0] strap_code;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_cnt_q  <= 16'h0000;
      pg_q      <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      capture_q <= 1'b0;
      if (!pg_q) begin
        if (pg_cnt_q == PG_LAST) begin
          pg_q      <= 1'b1;
          capture_q <= 1'b1;
        end else begin
          pg_cnt_q <= pg_cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_cnt_q <= 10'h000;
      bias_q     <= 1'b1;
      latched_q  <= 1'b0;
    end else begin
      if (capture_q) begin
        latched_q <= 1'b1;
      end
      if (latched_q && bias_q) begin
        if (hold_cnt_q == HOLD_LAST) begin
          bias_q <= 1'b0;
        end else begin
          hold_cnt_q <= hold_cnt_q + 10'h001;
        end
      end
    end
  end

  assign strap_lvl[STRAP_MODE]    = mode_strap;
  assign strap_lvl[STRAP_EQ0]     = conn_rx_eq_straps[0];
  assign strap_lvl[STRAP_EQ1]     = conn_rx_eq_straps[1];
  assign strap_lvl[STRAP_SSEQ0]   = host_tx_eq_straps[0];
  assign strap_lvl[STRAP_SSEQ1]   = host_tx_eq_straps[1];
  assign strap_lvl[STRAP_ADDR_HI] = addr_hi_strap;

  strap_latch u_straps (
    .clk     (clk),
    .rst_n   (rst_n),
    .capture (capture_q),
    .level   (strap_lvl),
    .code    (strap_code)
  );

  // Low address strap shares the first host-side equalization strap
  strap_code_type addr_lo_strap;
  logic [4:0]     addr_upper;
  logic [6:0]     addr_d;
  logic           mode_i2c;

  assign addr_lo_strap = strap_code[STRAP_SSEQ0];
  assign mode_i2c      = latched_q && (strap_code[STRAP_MODE] != LEVEL_0);

  always_comb begin
    case (strap_code[STRAP_ADDR_HI])
      LEVEL_R: addr_upper = ADDR_UPPER_R;
      LEVEL_F: addr_upper = ADDR_UPPER_F;
      LEVEL_1: addr_upper = ADDR_UPPER_1;
      default: addr_upper = ADDR_UPPER_0;
    endcase
    addr_d = {addr_upper, addr_lo_strap};
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C target and register file
  logic [7:0]    ctrl_q;
  logic [7:0]    rx_eq_q;
  logic [7:0]    host_eq_q;
  logic [7:0]    ptr_q;
  logic [7:0]    shift_q;
  logic [7:0]    tx_q;
  logic [3:0]    bit_cnt_q;
  logic          rw_q;
  logic          racked_q;
  logic          scl_q;
  logic          sda_q;
  logic          drive_q;
  i2c_state_type i2c_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  logic [7:0]    rd_byte;
  link_state_type ls_q;

  assign scl_rise   = scl && !scl_q;
  assign scl_fall   = !scl && scl_q;
  assign start_seen = scl && scl_q && sda_q && !sda_in;
  assign stop_seen  = scl && scl_q && !sda_q && sda_in;

  always_comb begin
    case (ptr_q)
      REG_CTRL:    rd_byte = ctrl_q;
      REG_RX_EQ:   rd_byte = rx_eq_q;
      REG_HOST_EQ: rd_byte = host_eq_q;
      REG_STATUS:  rd_byte = {4'h0, ls_q};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i2c_q     <= I2C_IDLE;
      ptr_q     <= 8'h00;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      bit_cnt_q <= 4'h0;
      rw_q      <= 1'b0;
      racked_q  <= 1'b0;
      drive_q   <= 1'b0;
      ctrl_q    <= CTRL_RESET;
      rx_eq_q   <= RX_EQ_RESET;
      host_eq_q <= HOST_EQ_RESET;
    end else if (!mode_i2c) begin
      i2c_q   <= I2C_IDLE;
      drive_q <= 1'b0;
    end else if (start_seen) begin
      i2c_q     <= I2C_ADDR;
      bit_cnt_q <= 4'h0;
      drive_q   <= 1'b0;
    end else if (stop_seen) begin
      i2c_q   <= I2C_IDLE;
      drive_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_q   <= {shift_q[6:0], sda_in};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (i2c_q == I2C_RACK) begin
          racked_q <= !sda_in;
        end
      end
      case (i2c_q)
        I2C_IDLE, I2C_WAIT_P: begin
          drive_q <= 1'b0;
        end
        I2C_ADDR: begin
          if (scl_fall && bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == target_addr) begin
              rw_q    <= shift_q[0];
              drive_q <= 1'b1;
              i2c_q   <= I2C_ADDR_ACK;
            end else begin
              i2c_q <= I2C_WAIT_P;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              tx_q    <= rd_byte;
              drive_q <= !rd_byte[7];
              ptr_q   <= ptr_q + 8'h01;
              i2c_q   <= I2C_RDATA;
            end else begin
              drive_q <= 1'b0;
              i2c_q   <= I2C_OFFS;
            end
          end
        end
        I2C_OFFS: begin
          if (scl_fall && bit_cnt_q == 4'h8) begin
            ptr_q   <= shift_q;
            drive_q <= 1'b1;
            i2c_q   <= I2C_OFFS_ACK;
          end
        end
        I2C_OFFS_ACK, I2C_WACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            drive_q   <= 1'b0;
            i2c_q     <= I2C_WDATA;
          end
        end
        I2C_WDATA: begin
          if (scl_fall && bit_cnt_q == 4'h8) begin
            case (ptr_q)
              REG_CTRL:    ctrl_q    <= shift_q;
              REG_RX_EQ:   rx_eq_q   <= shift_q;
              REG_HOST_EQ: host_eq_q <= shift_q;
              default:     ;
            endcase
            ptr_q   <= ptr_q + 8'h01;
            drive_q <= 1'b1;
            i2c_q   <= I2C_WACK;
          end
        end
        I2C_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              drive_q   <= 1'b0;
              bit_cnt_q <= 4'h0;
              i2c_q     <= I2C_RACK;
            end else begin
              tx_q    <= {tx_q[6:0], 1'b0};
              drive_q <= !tx_q[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (racked_q) begin
              tx_q    <= rd_byte;
              drive_q <= !rd_byte[7];
              ptr_q   <= ptr_q + 8'h01;
              i2c_q   <= I2C_RDATA;
            end else begin
              i2c_q <= I2C_WAIT_P;
            end
          end
        end
        default: begin
          i2c_q   <= I2C_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Path steering and equalization
  logic       path_en;
  logic       orient;
  eq_set_type eq_d;

  always_comb begin
    if (mode_i2c) begin
      path_en  = ctrl_q[CTRL_PATH_EN_BIT];
      orient   = ctrl_q[CTRL_ORIENT_BIT];
      eq_d.rx1  = rx_eq_q[3:0];
      eq_d.rx2  = rx_eq_q[7:4];
      eq_d.host = host_eq_q[3:0];
    end else begin
      path_en   = path_enable_pin;
      orient    = orientation_pin;
      eq_d.rx1  = {strap_code[STRAP_EQ1], strap_code[STRAP_EQ0]};
      eq_d.rx2  = {strap_code[STRAP_EQ1], strap_code[STRAP_EQ0]};
      eq_d.host = {strap_code[STRAP_SSEQ1], strap_code[STRAP_SSEQ0]};
    end
  end

  logic       path_q;
  logic       orient_q;
  eq_set_type eq_q;
  logic [2:0] eq_en_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      path_q   <= 1'b0;
      orient_q <= 1'b0;
      eq_q     <= '0;
      eq_en_q  <= 3'h0;
    end else begin
      path_q   <= pg_q && path_en;
      orient_q <= orient;
      eq_q     <= eq_d;
      // Bit 2 rx1, bit 1 rx2, bit 0 host receiver
      eq_en_q  <= {!link_in.lfps_conn, !link_in.lfps_conn, !link_in.lfps_host};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link-state machine
  logic [19:0] det_cnt_q;
  logic        det_q;
  logic        both_term;
  logic        both_idle;
  logic        any_lfps;

  assign both_term = link_in.term_conn && link_in.term_host;
  assign both_idle = link_in.eidle_conn && link_in.eidle_host;
  assign any_lfps  = link_in.lfps_conn || link_in.lfps_host;

  always_ff @(posedge clk) begin
    if (!rst_n || !path_q) begin
      ls_q <= LS_DISCONNECT;
    end else begin
      case (ls_q)
        LS_DISCONNECT: begin
          if (both_term) begin
            ls_q <= LS_U0;
          end
        end
        LS_U0: begin
          if (both_idle) begin
            ls_q <= LS_U1;
          end
        end
        LS_U1: begin
          if (!both_idle) begin
            ls_q <= LS_U0;
          end else if (link_in.u2_entry_lfps) begin
            ls_q <= LS_U2U3;
          end
        end
        LS_U2U3: begin
          if (!both_term) begin
            ls_q <= LS_DISCONNECT;
          end else if (any_lfps) begin
            ls_q <= LS_U0;
          end
        end
        default: ls_q <= LS_DISCONNECT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      det_cnt_q <= 20'h00000;
      det_q     <= 1'b0;
    end else begin
      det_q <= 1'b0;
      if (pg_q && path_q && (ls_q == LS_DISCONNECT || ls_q == LS_U2U3)) begin
        if (det_cnt_q == DET_LAST) begin
          det_cnt_q <= 20'h00000;
          det_q     <= 1'b1;
        end else begin
          det_cnt_q <= det_cnt_q + 20'h00001;
        end
      end else begin
        det_cnt_q <= 20'h00000;
      end
    end
  end

  logic term_q;
  logic cm_q;
  logic redrive_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_q    <= 1'b0;
      cm_q      <= 1'b0;
      redrive_q <= 1'b0;
    end else begin
      term_q    <= path_q && (ls_q != LS_DISCONNECT);
      cm_q      <= path_q && (ls_q == LS_U0 || ls_q == LS_U1);
      redrive_q <= path_q && (ls_q == LS_U0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic [6:0] addr_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= 7'h00;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign target_addr   = addr_q;
  assign sda_out       = 1'b0;
  assign sda_oe        = drive_q;
  assign power_good    = pg_q;
  assign strap_bias_en = bias_q;
  assign i2c_mode      = latched_q && (strap_code[STRAP_MODE] != LEVEL_0);
  assign path_active   = path_q;
  assign orient_lane2  = orient_q;
  assign eq_set        = eq_q;
  assign eq_enable     = eq_en_q;
  assign link_state    = ls_q;
  assign rx_term_en    = term_q;
  assign tx_cm_en      = cm_q;
  assign redrive_en    = redrive_q;
  assign rx_detect_req = det_q;
endmodule : redriver_control

/* redriver_properties.sv */
// Purpose: Port assertions for redriver_control
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every redriver_control instance
`timescale 1ns/1ps
module redriver_properties #(
  parameter int unsigned PG_CYCLES = 20
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire redriver_pkg::link_in_type    link_in,
  input wire logic                         power_good,
  input wire logic                         strap_bias_en,
  input wire logic                         path_active,
  input wire logic [2:0]                   eq_enable,
  input wire redriver_pkg::link_state_type link_state,
  input wire logic                         rx_term_en,
  input wire logic                         tx_cm_en,
  input wire logic                         redrive_en
);
  import redriver_pkg::*;
  int unsigned up_q;
  logic        both_t;
  logic        go;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_q <= 0;
    end else if (up_q < PG_CYCLES + 4) begin
      up_q <= up_q + 1;
    end
  end
  assign both_t = link_in.term_conn && link_in.term_host;
  assign go = path_active;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pg_in_time: assert property (up_q >= PG_CYCLES + 3 |-> power_good)
    else $error("power good late");
  a_pg_holds: assert property (power_good |=> power_good)
    else $error("power good dropped");
  a_bias_after_pg: assert property ($fell(strap_bias_en) |-> power_good)
    else $error("bias dropped early");
  a_path_gate: assert property (!go && link_state == LS_DISCONNECT |=> link_state == LS_DISCONNECT)
    else $error("link left disconnect while off");
  a_disc_exit: assert property (go && link_state == LS_DISCONNECT && both_t |=> link_state == LS_U0)
    else $error("no exit from disconnect");
  a_u0_to_u1: assert property (go && link_state == LS_U0 && link_in.eidle_conn
    && link_in.eidle_host |=> link_state == LS_U1)
    else $error("no move to U1");
  a_u2_lfps: assert property (go && link_state == LS_U2U3 && both_t
    && (link_in.lfps_conn || link_in.lfps_host) |=> link_state == LS_U0)
    else $error("no wake on lfps");
  a_u2_loss: assert property (go && link_state == LS_U2U3 && !both_t |=> link_state == LS_DISCONNECT)
    else $error("no disconnect on lost term");
  a_term_follow: assert property (rx_term_en ==
    ($past(path_active) && $past(link_state) != LS_DISCONNECT))
    else $error("rx termination wrong");
  a_cm_follow: assert property (tx_cm_en ==
    ($past(path_active) && ($past(link_state) inside {LS_U0, LS_U1})))
    else $error("tx common mode wrong");
  a_redrive_u0: assert property (redrive_en ==
    ($past(path_active) && $past(link_state) == LS_U0))
    else $error("redrive wrong");
  a_eq_gate: assert property (power_good && $past(power_good) |-> eq_enable ==
    {{2{!$past(link_in.lfps_conn)}}, !$past(link_in.lfps_host)})
    else $error("eq gating wrong");
  c_pg: cover property ($rose(power_good));
  c_u1: cover property (link_state == LS_U1);
  c_u2: cover property (link_state == LS_U2U3);
endmodule : redriver_properties

bind redriver_control redriver_properties #(.PG_CYCLES(PG_CYCLES)) i_props (
  .clk(clk), .rst_n(rst_n), .link_in(link_in), .power_good(power_good),
  .strap_bias_en(strap_bias_en), .path_active(path_active), .eq_enable(eq_enable),
  .link_state(link_state), .rx_term_en(rx_term_en), .tx_cm_en(tx_cm_en),
  .redrive_en(redrive_en)
);

/* lane_partner.sv */
// Purpose: Far-side lane model giving link conditions
// Assumes: Phase code set by the bench on a clock edge
// Notes:   Bits: term c/h, idle c/h, lfps c/h, power-down lfps
`timescale 1ns/1ps
module lane_partner (
  input  wire logic [2:0]            phase,
  output redriver_pkg::link_in_type  link_in
);
  import redriver_pkg::*;
  always_comb begin
    case (phase)
      3'h1:    link_in = 7'b1100000;
      3'h2:    link_in = 7'b1111000;
      3'h3:    link_in = 7'b1111001;
      3'h4:    link_in = 7'b1100100;
      3'h5:    link_in = 7'b1100010;
      3'h6:    link_in = 7'b1011000;
      default: link_in = 7'b0011000;
    endcase
  end
endmodule : lane_partner

/* tb.sv */
// Purpose: Self-checking bench for redriver_control
// Assumes: Strap mode until t_i2c sets the mode strap under reset; other straps held stable from time zero
// Notes:   Short power-good and detect counts
`timescale 1ns/1ps
module tb;
  import redriver_pkg::*;
  localparam int unsigned PG = 20;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             path_pin = 1'b0;
  logic             ori = 1'b0;
  logic [2:0]       phase = 3'h1;
  logic             scl_r = 1'b1;
  logic             sda_r = 1'b1;
  strap_thermo_type mode_s = 3'h0;
  strap_thermo_type [1:0] rx_s = {THERMO_F, THERMO_R};
  strap_thermo_type [1:0] host_s = {3'h0, THERMO_1};
  strap_thermo_type hi_s = THERMO_F;
  link_in_type      link_in;
  logic             sda_oe, power_good, strap_bias_en, i2c_mode, path_active;
  logic             orient_lane2, rx_term_en, tx_cm_en, redrive_en, rx_detect_req;
  logic [6:0]       target_addr;
  eq_set_type       eq_set;
  logic [2:0]       eq_enable;
  link_state_type   link_state;
  int               err_total = 0;
  int               n_compared = 0;
  always #10 clk = ~clk;
  lane_partner i_lane (.phase(phase), .link_in(link_in));
  redriver_control #(.PG_CYCLES(PG), .RXDET_CYCLES(16)) i_dut (
    .clk(clk), .rst_n(rst_n), .mode_strap(mode_s), .conn_rx_eq_straps(rx_s),
    .host_tx_eq_straps(host_s), .addr_hi_strap(hi_s), .path_enable_pin(path_pin),
    .orientation_pin(ori), .link_in(link_in), .scl(scl_r), .sda_in(sda_r && !sda_oe),
    .sda_out(), .sda_oe(sda_oe), .power_good(power_good),
    .strap_bias_en(strap_bias_en), .i2c_mode(i2c_mode), .target_addr(target_addr),
    .path_active(path_active), .orient_lane2(orient_lane2), .eq_set(eq_set),
    .eq_enable(eq_enable), .link_state(link_state), .rx_term_en(rx_term_en),
    .tx_cm_en(tx_cm_en), .redrive_en(redrive_en), .rx_detect_req(rx_detect_req)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic t_power();
    int n;
    n = 0;
    while (power_good !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("pg_delay", 16'h1, 16'(n <= PG + 2));
    if (n >= 200) begin
      results();
    end
    tick(2);
    chk("i2c_mode", 16'h0, 16'(i2c_mode));
    chk("sda_idle", 16'h0, 16'(sda_oe));
    chk("target_addr", 16'h13, 16'(target_addr));
    chk("eq_set", 16'h993, 16'(eq_set));
    tick(490);
    chk("bias_held", 16'h1, 16'(strap_bias_en));
    tick(14);
    chk("bias_off", 16'h0, 16'(strap_bias_en));
  endtask : t_power
  task automatic t_path();
    chk("path_off", 16'h0, 16'(path_active));
    chk("held_disc", 16'(LS_DISCONNECT), 16'(link_state));
    @(posedge clk);
    path_pin <= 1'b1;
    phase <= 3'h0;
    tick(3);
    chk("path_on", 16'h1, 16'(path_active));
    chk("lane1", 16'h0, 16'(orient_lane2));
    @(posedge clk);
    ori <= 1'b1;
    tick(3);
    chk("lane2", 16'h1, 16'(orient_lane2));
  endtask : t_path
  task automatic count_det(input string what, input logic exp);
    int c;
    c = 0;
    repeat (40) begin
      tick(1);
      if (rx_detect_req === 1'b1) begin
        c++;
      end
    end
    chk(what, 16'(exp), 16'(c >= 2));
  endtask : count_det
  task automatic step(input logic [2:0] p, input link_state_type st, input logic [2:0] outs);
    @(posedge clk);
    phase <= p;
    tick(4);
    chk("link_state", 16'(st), 16'(link_state));
    chk("term_cm_drive", 16'(outs), 16'({rx_term_en, tx_cm_en, redrive_en}));
  endtask : step
  task automatic t_link();
    count_det("detect_disc", 1'b1);
    step(3'h1, LS_U0, 3'b111);
    count_det("detect_u0", 1'b0);
    step(3'h2, LS_U1, 3'b110);
    step(3'h1, LS_U0, 3'b111);
    step(3'h2, LS_U1, 3'b110);
    step(3'h3, LS_U2U3, 3'b100);
    count_det("detect_u2", 1'b1);
    step(3'h4, LS_U0, 3'b111);
    chk("eq_lfps_conn", 16'h1, 16'(eq_enable));
    step(3'h5, LS_U0, 3'b111);
    chk("eq_lfps_host", 16'h6, 16'(eq_enable));
    step(3'h1, LS_U0, 3'b111);
    chk("eq_on", 16'h7, 16'(eq_enable));
    step(3'h2, LS_U1, 3'b110);
    step(3'h3, LS_U2U3, 3'b100);
    step(3'h6, LS_DISCONNECT, 3'b000);
  endtask : t_link
  task automatic pin(input logic c, input logic d);
    @(posedge clk);
    scl_r <= c;
    sda_r <= d;
    repeat (2) @(posedge clk);
  endtask : pin
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pin(1'b0, b[i]);
      pin(1'b1, b[i]);
    end
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    #1;
    chk("i2c_ack", 16'h1, 16'(sda_oe));
  endtask : send
  task automatic t_i2c();
    @(posedge clk);
    rst_n <= 1'b0;
    mode_s <= THERMO_1;
    tick(3);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(PG + 4);
    chk("i2c_mode_on", 16'h1, 16'(i2c_mode));
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    send(8'h26);
    send(8'h00);
    send(8'h03);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    tick(3);
    chk("i2c_path", 16'h1, 16'(path_active));
    chk("i2c_orient", 16'h1, 16'(orient_lane2));
  endtask : t_i2c
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_path();
    t_link();
    t_i2c();
    results();
  end
endmodule : tb
